// ---- common/vip_pkg.sv ----
// Shared constants and carrier types for the vectored interrupt prioritizer.
// Assumes one 50 MHz clock and an APB master with 32-bit data.
package vip_pkg;

  // Vector space: index 0 is reset, index 1 the non-maskable vector
  localparam int VIP_NUM_VEC = 32;
  localparam int VIP_VEC_W = 5;
  localparam logic [7:0] VIP_RESET_VEC = 8'h00;
  localparam logic [7:0] VIP_NMI_VEC = 8'h01;
  localparam logic [31:0] VIP_NMI_MASK = 32'h0000_0002;
  localparam logic [31:0] VIP_RESET_MASK = 32'h0000_0001;

  // Vectors issued while the compact table is enabled
  localparam logic [7:0] VIP_COMPACT_NMI = 8'h01;
  localparam logic [7:0] VIP_COMPACT_HIGH = 8'h02;
  localparam logic [7:0] VIP_COMPACT_NORMAL = 8'h03;

  // Register indices; byte address is four times the index
  localparam logic [9:0] VIP_IDX_CTRL = 10'h000;
  localparam logic [9:0] VIP_IDX_STATUS = 10'h001;
  localparam logic [9:0] VIP_IDX_POINTER = 10'h002;
  localparam logic [9:0] VIP_IDX_HIGHVEC = 10'h003;
  localparam int VIP_ADDR_W = 12;

  // Field positions
  localparam int VIP_CTRL_ROTATE_BIT = 0;
  localparam int VIP_CTRL_COMPACT_BIT = 5;
  localparam int VIP_CTRL_VBASE_BIT = 6;
  localparam int VIP_STAT_NORMAL_BIT = 0;
  localparam int VIP_STAT_HIGH_BIT = 1;
  localparam int VIP_STAT_NMI_BIT = 7;

  // Reset values
  localparam logic [7:0] VIP_CTRL_RST = 8'h00;
  localparam logic [7:0] VIP_POINTER_RST = 8'h00;
  localparam logic [7:0] VIP_HIGHVEC_RST = 8'h00;

  // Guard window length in retired core instructions
  localparam logic [2:0] VIP_GUARD_INSTR = 3'h4;

  typedef enum logic [1:0] {
    VIP_LVL_NONE,
    VIP_LVL_NORMAL,
    VIP_LVL_HIGH,
    VIP_LVL_NMI
  } vip_level_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [VIP_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } vip_apb_req_s;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } vip_apb_rsp_s;

  typedef struct packed {
    logic valid;
    logic [7:0] vector;
    logic [7:0] source;
    vip_level_e level;
  } vip_ack_s;

endpackage : vip_pkg

// ---- design/vip_first_set.sv ----
// Lowest-index finder for a request bitmap.
// Purely combinational; the caller registers whatever it needs.
`timescale 1ns/1ps
module vip_first_set #(
  parameter int W = 32,
  parameter int IW = 5
) (
  input wire logic [W-1:0] req,
  output logic found,
  output logic [IW-1:0] index
);

  // Scan from the top so the lowest set bit is the last to win
  always_comb begin
    found = 1'b0;
    index = '0;
    for (int i = W - 1; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        index = IW'(i);
      end
    end
  end

endmodule : vip_first_set

// ---- design/vip_prioritizer.sv ----
// Interrupt priority controller: arbitration, level tracking, APB registers.
// Assumes the core retires the ack in the cycle it is shown, signals each
// return-from-handler and each retired instruction with one-cycle pulses,
// and reports its global enable flag as a level.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
module vip_prioritizer (
  input wire logic pclk,
  input wire logic presetn,
  input wire vip_pkg::vip_apb_req_s apb_req,
  output vip_pkg::vip_apb_rsp_s apb_rsp,
  input wire logic [vip_pkg::VIP_NUM_VEC-1:0] irq_req,
  input wire logic global_enable,
  input wire logic return_from_handler,
  input wire logic io_register_key,
  input wire logic instr_done,
  output vip_pkg::vip_ack_s ack,
  output logic vector_base_select
);
  import vip_pkg::*;

  // Whole state of the block
  typedef struct packed {
    logic rotate_priority_enable;
    logic compact_table_enable;
    logic vector_base_select;
    logic [7:0] normal_lowest_pointer;
    logic [7:0] promoted_vector_number;
    logic nonmaskable_active;
    logic high_level_active;
    logic normal_level_active;
    logic [2:0] guard_count;
    vip_apb_rsp_s rsp;
    vip_ack_s ack;
  } vip_state_s;

  vip_state_s state;
  vip_state_s next_state;

  // Pending sets per level
  logic [VIP_NUM_VEC-1:0] nmi_pend;
  logic [VIP_NUM_VEC-1:0] normal_pend;
  logic [VIP_NUM_VEC-1:0] rotated_pend;
  logic [2*VIP_NUM_VEC-1:0] doubled_pend;
  logic [VIP_VEC_W-1:0] rot_shift;
  logic nmi_found;
  logic [VIP_VEC_W-1:0] nmi_index;
  logic normal_found;
  logic [VIP_VEC_W-1:0] normal_rot_index;
  logic [VIP_VEC_W-1:0] normal_index;
  logic high_valid;
  logic high_pend;
  vip_level_e cur_level;

  // APB decode
  logic [9:0] reg_index;
  logic addr_mapped;
  logic setup_phase;
  logic write_commit;
  logic [7:0] read_byte;
  logic [7:0] ctrl_read;
  logic [7:0] status_read;

  // Non-maskable set never includes the reset vector
  // reset and non-maskable kept outside rotation
  assign nmi_pend = irq_req & VIP_NMI_MASK & ~VIP_RESET_MASK;

  // zero, reset or non-maskable vector promotes nothing
  assign high_valid = (state.promoted_vector_number != VIP_RESET_VEC)
    && (state.promoted_vector_number != VIP_NMI_VEC)
    && (state.promoted_vector_number < 8'(VIP_NUM_VEC));
  assign high_pend = high_valid
    && irq_req[state.promoted_vector_number[VIP_VEC_W-1:0]];

  // normal set is every vector above the non-maskable one except the promoted one
  always_comb begin
    normal_pend = irq_req & ~VIP_NMI_MASK & ~VIP_RESET_MASK;
    if (high_valid) begin
      normal_pend[state.promoted_vector_number[VIP_VEC_W-1:0]] = 1'b0;
    end
  end

  // rotate so the vector after the pointer sits at bit 0
  assign rot_shift = VIP_VEC_W'(state.normal_lowest_pointer[VIP_VEC_W-1:0] + 1'b1);
  assign doubled_pend = {normal_pend, normal_pend} >> rot_shift;
  assign rotated_pend = doubled_pend[VIP_NUM_VEC-1:0];
  // pointer zero leaves vector 2 upward in fixed order
  assign normal_index = VIP_VEC_W'(normal_rot_index + rot_shift);

  // lowest non-maskable vector wins among simultaneous ones
  vip_first_set #(
    .W(VIP_NUM_VEC),
    .IW(VIP_VEC_W)
  ) u_nmi_pick (
    .req(nmi_pend),
    .found(nmi_found),
    .index(nmi_index)
  );

  // Lowest rotated position wins among normal requests
  vip_first_set #(
    .W(VIP_NUM_VEC),
    .IW(VIP_VEC_W)
  ) u_normal_pick (
    .req(rotated_pend),
    .found(normal_found),
    .index(normal_rot_index)
  );

  // Executing level from the status bits, highest first
  always_comb begin
    if (state.nonmaskable_active) begin
      cur_level = VIP_LVL_NMI;
    end else if (state.high_level_active) begin
      cur_level = VIP_LVL_HIGH;
    end else if (state.normal_level_active) begin
      cur_level = VIP_LVL_NORMAL;
    end else begin
      cur_level = VIP_LVL_NONE;
    end
  end

  // Register read images
  always_comb begin
    ctrl_read = 8'h00;
    ctrl_read[VIP_CTRL_ROTATE_BIT] = state.rotate_priority_enable;
    ctrl_read[VIP_CTRL_COMPACT_BIT] = state.compact_table_enable;
    ctrl_read[VIP_CTRL_VBASE_BIT] = state.vector_base_select;
    status_read = 8'h00;
    status_read[VIP_STAT_NORMAL_BIT] = state.normal_level_active;
    status_read[VIP_STAT_HIGH_BIT] = state.high_level_active;
    status_read[VIP_STAT_NMI_BIT] = state.nonmaskable_active;
  end

  // Address decode on aligned words
  assign reg_index = apb_req.paddr[VIP_ADDR_W-1:2];
  assign addr_mapped = (apb_req.paddr[1:0] == 2'h0) && (reg_index <= VIP_IDX_HIGHVEC);
  assign setup_phase = apb_req.psel && !apb_req.penable;
  assign write_commit = apb_req.psel && apb_req.penable && state.rsp.pready
    && apb_req.pwrite && addr_mapped && apb_req.pstrb[0];

  // Read mux, unmapped reads return zero
  always_comb begin
    case (reg_index)
      VIP_IDX_CTRL: read_byte = ctrl_read;
      VIP_IDX_STATUS: read_byte = status_read;
      VIP_IDX_POINTER: read_byte = state.normal_lowest_pointer;
      VIP_IDX_HIGHVEC: read_byte = state.promoted_vector_number;
      default: read_byte = 8'h00;
    endcase
  end

  // Next-state logic
  always_comb begin
    next_state = state;
    next_state.ack.valid = 1'b0;

    // Bus answer prepared in setup, shown during the single access cycle
    next_state.rsp.pready = setup_phase;
    if (setup_phase) begin
      next_state.rsp.prdata = addr_mapped ? {24'h000000, read_byte} : 32'h0000_0000;
      next_state.rsp.pslverr = !addr_mapped;
    end else begin
      next_state.rsp.prdata = 32'h0000_0000;
      next_state.rsp.pslverr = 1'b0;
    end

    // Guard window counts retired instructions after the key
    // unlock lasts four instructions after the key
    if (io_register_key) begin
      next_state.guard_count = VIP_GUARD_INSTR;
    end else if (instr_done && state.guard_count != 3'h0) begin
      next_state.guard_count = 3'(state.guard_count - 1'b1);
    end

    // Software register writes
    if (write_commit) begin
      case (reg_index)
        VIP_IDX_CTRL: begin
          // bit 0 picks fixed or rotating order
          next_state.rotate_priority_enable = apb_req.pwdata[VIP_CTRL_ROTATE_BIT];
          // guarded bits need an open window
          if (state.guard_count != 3'h0) begin
            // bit 5 is the compact table enable
            next_state.compact_table_enable = apb_req.pwdata[VIP_CTRL_COMPACT_BIT];
            // bit 6 picks boot or application base
            next_state.vector_base_select = apb_req.pwdata[VIP_CTRL_VBASE_BIT];
            next_state.guard_count = 3'h0;
          end
        end
        VIP_IDX_POINTER: next_state.normal_lowest_pointer = apb_req.pwdata[7:0];
        VIP_IDX_HIGHVEC: next_state.promoted_vector_number = apb_req.pwdata[7:0];
        default: begin
        end
      endcase
    end

    // a return clears the innermost level, restoring the prior one
    if (return_from_handler) begin
      if (state.nonmaskable_active) begin
        // non-maskable flag drops on its return
        next_state.nonmaskable_active = 1'b0;
      end else if (state.high_level_active) begin
        // high flag drops on its own return
        next_state.high_level_active = 1'b0;
      end else begin
        // normal flag drops on its own return
        next_state.normal_level_active = 1'b0;
      end
    end else begin
      // grant only when the level beats the executing one
      // non-maskable ignores enable and is never preempted
      if (nmi_found && cur_level != VIP_LVL_NMI) begin
        next_state.ack.valid = 1'b1;
        next_state.ack.source = 8'(nmi_index);
        next_state.ack.level = VIP_LVL_NMI;
        next_state.ack.vector = state.compact_table_enable ? VIP_COMPACT_NMI : 8'(nmi_index);
        next_state.nonmaskable_active = 1'b1;
      // maskable grants need the global enable
      // high request preempts a normal handler
      end else if (high_pend && global_enable
          && (cur_level == VIP_LVL_NONE || cur_level == VIP_LVL_NORMAL)) begin
        next_state.ack.valid = 1'b1;
        next_state.ack.source = state.promoted_vector_number;
        next_state.ack.level = VIP_LVL_HIGH;
        next_state.ack.vector = state.compact_table_enable ? VIP_COMPACT_HIGH
          : state.promoted_vector_number;
        next_state.high_level_active = 1'b1;
      end else if (normal_found && global_enable && cur_level == VIP_LVL_NONE) begin
        next_state.ack.valid = 1'b1;
        next_state.ack.source = 8'(normal_index);
        next_state.ack.level = VIP_LVL_NORMAL;
        next_state.ack.vector = state.compact_table_enable ? VIP_COMPACT_NORMAL
          : 8'(normal_index);
        next_state.normal_level_active = 1'b1;
        // only the normal branch moves the pointer
        if (state.rotate_priority_enable) begin
          next_state.normal_lowest_pointer = 8'(normal_index);
        end
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state.rotate_priority_enable <= VIP_CTRL_RST[VIP_CTRL_ROTATE_BIT];
      state.compact_table_enable <= VIP_CTRL_RST[VIP_CTRL_COMPACT_BIT];
      state.vector_base_select <= VIP_CTRL_RST[VIP_CTRL_VBASE_BIT];
      state.normal_lowest_pointer <= VIP_POINTER_RST;
      state.promoted_vector_number <= VIP_HIGHVEC_RST;
      state.nonmaskable_active <= 1'b0;
      state.high_level_active <= 1'b0;
      state.normal_level_active <= 1'b0;
      state.guard_count <= 3'h0;
      state.rsp <= '0;
      state.ack <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from the state flops
  assign apb_rsp = state.rsp;
  assign ack = state.ack;
  assign vector_base_select = state.vector_base_select;

endmodule : vip_prioritizer

// ---- test/vip_core_model.sv ----
// Core-side partner: return, guard-key and retire pulses for the prioritizer.
// Assumes the bench raises ret_cmd and key_cmd for one cycle after a rising edge, and holds run while instructions retire.
`timescale 1ns/1ps
module vip_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ret_cmd,
  input wire logic key_cmd,
  input wire logic run,
  output logic return_from_handler,
  output logic io_register_key,
  output logic instr_done
);
  // Registered one-cycle pulses, quiet in reset
  // key, then few retires
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      return_from_handler <= 1'h0;
      io_register_key <= 1'h0;
      instr_done <= 1'h0;
    end else begin
      return_from_handler <= ret_cmd;
      io_register_key <= key_cmd;
      instr_done <= run;
    end
  end
endmodule : vip_core_model

// ---- test/vip_prioritizer_monitor.sv ----
// Port-level checks on the interrupt prioritizer.
// Assumes one pclk domain and asynchronous active-low presetn.
`timescale 1ns/1ps
module vip_prioritizer_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire vip_pkg::vip_apb_req_s apb_req,
  input wire vip_pkg::vip_apb_rsp_s apb_rsp,
  input wire logic [vip_pkg::VIP_NUM_VEC-1:0] irq_req,
  input wire logic global_enable,
  input wire logic return_from_handler,
  input wire logic io_register_key,
  input wire logic instr_done,
  input wire vip_pkg::vip_ack_s ack,
  input wire logic vector_base_select
);
  import vip_pkg::*;
  logic [31:0] req_q;
  logic [2:0] guard_q;
  // Requests as seen at the deciding edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_q <= '0;
    end else begin
      req_q <= irq_req;
    end
  end
  // Guard window as seen from the core pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      guard_q <= 3'h0;
    end else if (io_register_key) begin
      guard_q <= VIP_GUARD_INSTR;
    end else if (instr_done && guard_q != 3'h0) begin
      guard_q <= 3'(guard_q - 3'h1);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_grant_enable: assert property (
    ack.valid && ack.level != VIP_LVL_NMI |-> $past(global_enable))
    else $error("Maskable grant without enable");
  a_nmi_first: assert property (
    ack.valid && req_q[1] |-> ack.level == VIP_LVL_NMI)
    else $error("Grant other than pending nonmaskable");
  a_grant_pending: assert property (
    ack.valid |-> req_q[ack.source[4:0]])
    else $error("Granted vector was not pending");
  a_return_no_grant: assert property (
    return_from_handler |=> !ack.valid)
    else $error("Grant in a return cycle");
  a_compact_vec: assert property (
    ack.valid && ack.vector != ack.source |-> ack.vector == 8'(4 - ack.level))
    else $error("Compact vector does not match level");
  a_ready_pulse: assert property (
    apb_req.psel && !apb_req.penable |=> apb_rsp.pready ##1 !apb_rsp.pready)
    else $error("Ready not a single access pulse");
  a_slave_error: assert property (
    apb_rsp.pready |-> apb_rsp.pslverr
      == (apb_req.paddr[1:0] != 2'h0 || apb_req.paddr[11:2] > 10'h003))
    else $error("Wrong slave error");
  a_base_on_write: assert property (
    !$stable(vector_base_select) |-> $past(apb_rsp.pready && apb_req.pwrite
      && apb_req.paddr == 12'h000 && guard_q != 3'h0))
    else $error("Vector base moved without a control write");
endmodule : vip_prioritizer_monitor

bind vip_prioritizer vip_prioritizer_monitor vip_prioritizer_monitor_i (.pclk(pclk),
  .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .irq_req(irq_req),
  .global_enable(global_enable), .return_from_handler(return_from_handler),
  .io_register_key(io_register_key), .instr_done(instr_done), .ack(ack),
  .vector_base_select(vector_base_select));

// ---- test/vip_prioritizer_tb_top.sv ----
// Bench for the interrupt prioritizer: APB tasks and request sequences.
// Assumes the core model drives return, key and retire pulses.
`timescale 1ns/1ps
module vip_prioritizer_tb_top;
  import vip_pkg::*;
  logic pclk;
  logic presetn;
  vip_apb_req_s req;
  vip_apb_rsp_s rsp;
  logic [31:0] irq;
  logic ge, ret_cmd, key_cmd, run, rfh, key, idone, vbs;
  vip_ack_s ack;
  int n_mismatch = 0;
  int cmp_count = 0;
  int n_ack = 0;
  int n_taken = 0;
  logic [32:0] r;

  vip_prioritizer vip_prioritizer_i (.pclk(pclk), .presetn(presetn), .apb_req(req),
    .apb_rsp(rsp), .irq_req(irq), .global_enable(ge), .return_from_handler(rfh),
    .io_register_key(key), .instr_done(idone), .ack(ack), .vector_base_select(vbs));
  vip_core_model vip_core_model_i (.pclk(pclk), .presetn(presetn), .ret_cmd(ret_cmd),
    .key_cmd(key_cmd), .run(run), .return_from_handler(rfh), .io_register_key(key),
    .instr_done(idone));

  // 50 MHz clock
  initial begin
    pclk = 1'h0;
    forever #10 pclk = ~pclk;
  end

  // Count acknowledge pulses
  always @(posedge pclk) begin
    if (ack.valid === 1'h1) n_ack <= n_ack + 1;
  end

  task automatic end_sim();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; result is {pslverr, prdata}
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    req <= {1'h1, 1'h0, w, a, 24'h000000, d, 4'hF};
    @(posedge pclk);
    req.penable <= 1'h1;
    // Hold the access until ready; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (rsp.pready !== 1'h1);
    r = {rsp.pslverr, rsp.prdata};
    req.psel <= 1'h0;
    req.penable <= 1'h0;
    // Idle edge so the next setup never reassigns in this step
    @(posedge pclk);
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    apb(1'h0, a, 8'h00);
    chk(r, e);
  endtask : rd

  // Wait a bounded time for a grant, then check it
  task automatic ackx(input logic [7:0] s, input logic [7:0] v, input vip_level_e l);
    repeat (8) if (n_ack == n_taken) @(posedge pclk);
    chk(33'(n_ack - n_taken), 33'(l != VIP_LVL_NONE));
    if (n_ack > n_taken) chk({15'h0000, ack.source, ack.vector, ack.level}, {15'h0000, s, v, l});
    n_taken = n_ack;
  endtask : ackx

  task automatic pulse(input logic is_key);
    if (is_key) key_cmd <= 1'h1;
    else ret_cmd <= 1'h1;
    @(posedge pclk);
    key_cmd <= 1'h0;
    ret_cmd <= 1'h0;
    repeat (3) @(posedge pclk);
  endtask : pulse

  // Watchdog
  initial begin
    repeat (3000) @(posedge pclk);
    n_mismatch++;
    end_sim();
  end

  // Main sequence
  initial begin
    presetn = 1'h0;
    req = '0;
    irq = '0;
    {ge, ret_cmd, key_cmd, run} = 4'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++) rd(12'(i * 4), 33'h0);
    rd(12'h010, 33'h100000000);
    rd(12'h005, 33'h100000000);
    apb(1'h1, 12'h004, 8'hFF);
    rd(12'h004, 33'h0);
    apb(1'h1, 12'h000, 8'h61);
    rd(12'h000, 33'h1);
    pulse(1'h1);
    run <= 1'h1;
    repeat (6) @(posedge pclk);
    run <= 1'h0;
    apb(1'h1, 12'h000, 8'h60);
    // Window closed: only the rotate bit takes the written zero
    rd(12'h000, 33'h0);
    apb(1'h1, 12'h000, 8'h00);
    ge <= 1'h1;
    irq <= 32'h00000210;
    ackx(8'h04, 8'h04, VIP_LVL_NORMAL);
    rd(12'h004, 33'h1);
    irq <= 32'h00000200;
    pulse(1'h0);
    ackx(8'h09, 8'h09, VIP_LVL_NORMAL);
    irq <= 32'h0;
    pulse(1'h0);
    apb(1'h1, 12'h008, 8'h09);
    irq <= 32'h00001210;
    ackx(8'h0C, 8'h0C, VIP_LVL_NORMAL);
    irq <= 32'h00000210;
    pulse(1'h0);
    ackx(8'h04, 8'h04, VIP_LVL_NORMAL);
    rd(12'h008, 33'h9);
    irq <= 32'h0;
    pulse(1'h0);
    apb(1'h1, 12'h000, 8'h01);
    irq <= 32'h00000020;
    ackx(8'h05, 8'h05, VIP_LVL_NORMAL);
    rd(12'h008, 33'h5);
    apb(1'h1, 12'h00C, 8'h07);
    irq <= 32'h000000A0;
    ackx(8'h07, 8'h07, VIP_LVL_HIGH);
    irq <= 32'h000000A2;
    ackx(8'h01, 8'h01, VIP_LVL_NMI);
    rd(12'h004, 33'h83);
    rd(12'h008, 33'h5);
    irq <= 32'h00000020;
    pulse(1'h0);
    rd(12'h004, 33'h3);
    irq <= 32'h0;
    pulse(1'h0);
    rd(12'h004, 33'h1);
    pulse(1'h0);
    ge <= 1'h0;
    irq <= 32'h00000020;
    ackx(8'h00, 8'h00, VIP_LVL_NONE);
    irq <= 32'h00000022;
    ackx(8'h01, 8'h01, VIP_LVL_NMI);
    irq <= 32'h0;
    pulse(1'h0);
    ge <= 1'h1;
    pulse(1'h1);
    apb(1'h1, 12'h000, 8'h61);
    rd(12'h000, 33'h61);
    chk({32'h00000000, vbs}, 33'h1);
    irq <= 32'h00000040;
    ackx(8'h06, 8'h03, VIP_LVL_NORMAL);
    irq <= 32'h000000C0;
    ackx(8'h07, 8'h02, VIP_LVL_HIGH);
    irq <= 32'h000000C2;
    ackx(8'h01, 8'h01, VIP_LVL_NMI);
    irq <= 32'h0;
    repeat (3) pulse(1'h0);
    rd(12'h004, 33'h0);
    end_sim();
  end
endmodule : vip_prioritizer_tb_top
